// *** add_family_consts.svh ***
// constants for the accumulator add datapath: opcodes, reset values, widths
// assumes inclusion by its bare name
`ifndef ADD_FAMILY_CONSTS_SVH
`define ADD_FAMILY_CONSTS_SVH

`define OP_ADD_CARRY_HI    8'h0c
`define OP_LONG_ADD_HI     8'h07
`define OP_ADD_PRODUCT     16'h10ac
`define OP_ADD_TO_MEM      16'h5601
`define OP_ADD_TO_MEM_EXT  8'h00
`define SAT_POS_VALUE      32'h7fffffff
`define SAT_NEG_VALUE      32'h80000000
`define SUM_RESET          32'h00000000
`define SHIFT_LEFT_ONE     3'h0
`define SHIFT_RIGHT_BIAS   3'h1
`define REP_COUNT_W        8
`define OVC_DEFAULT_W      6

`endif

// *** add_family_pkg.sv ***
// types shared by the accumulator add datapath
// assumes nothing beyond a SystemVerilog compiler
package add_family_pkg;

  typedef enum logic [1:0] {
    op_add_carry  = 2'b00,
    op_long_add   = 2'b01,
    op_add_prod   = 2'b10,
    op_add_to_mem = 2'b11
  } op_kind_t;

  typedef enum logic {
    st_idle   = 1'b0,
    st_repeat = 1'b1
  } seq_state_t;

endpackage

// *** adder_if.sv ***
// operand and result bundle between the sequencer and the adder core
// assumes both ends run in the core clock domain
`timescale 1ns/10ps
`default_nettype none

interface adder_if;
  logic [31:0] a;
  logic [31:0] b;
  logic        cin;
  logic        sat;
  logic [31:0] result;
  logic        carry;
  logic        ovf_pos;
  logic        ovf_neg;

  modport seq   (output a, b, cin, sat, input result, carry, ovf_pos, ovf_neg);
  modport adder (input a, b, cin, sat, output result, carry, ovf_pos, ovf_neg);
endinterface

`default_nettype wire

// *** sat_adder.sv ***
// combinational 32-bit adder with carry, signed overflow and saturation
// assumes its inputs are held stable within the core clock cycle
`timescale 1ns/10ps
`default_nettype none

module sat_adder
  import add_family_pkg::*;
(
  adder_if.adder bus
);
`include "add_family_consts.svh"

  wire [32:0] raw_sum;
  wire        same_sign;
  wire        sign_flip;

  // -------------------------------------------------------------------
  // sum and overflow
  // -------------------------------------------------------------------
  assign raw_sum     = {1'b0, bus.a} + {1'b0, bus.b} + {32'h0, bus.cin};
  assign bus.carry   = raw_sum[32];
  assign same_sign   = (bus.a[31] == bus.b[31]);
  assign sign_flip   = (raw_sum[31] != bus.a[31]);
  assign bus.ovf_pos = same_sign & sign_flip & ~bus.a[31];
  assign bus.ovf_neg = same_sign & sign_flip & bus.a[31];

  // -------------------------------------------------------------------
  // saturation
  // -------------------------------------------------------------------
  assign bus.result = (bus.sat && bus.ovf_pos) ? `SAT_POS_VALUE :
                      (bus.sat && bus.ovf_neg) ? `SAT_NEG_VALUE :
                      raw_sum[31:0];

endmodule

`default_nettype wire

// *** accumulator_add_family.sv ***
// execution datapath for the four accumulator add instructions
// assumes opcode fetch, operand fetch and memory write handling live outside
//
// Contract
// - upper byte 0x0c decodes unsigned add with carry
// - zero-extend 16-bit operand, add it plus carry
// - carry before execution feeds in, then overwritten
// - upper byte 0x07 decodes 32-bit memory add
// - opcode 0x10ac adds shifted product register
// - left shift zero fills, right shift sign extends
// - 0x5601 in compat mode adds into memory
// - negative flag copies result bit 31
// - carry flag follows carry out
// - overflow flag only ever set here
// - counter steps on overflow unless saturating
// - repeated memory or product add runs count+1
// - zero, negative, carry reflect final iteration
// - any iteration overflow sets overflow flag
// - counter counts every iteration overflow unless saturating
`timescale 1ns/10ps
`default_nettype none
`include "add_family_consts.svh"

module accumulator_add_family
  import add_family_pkg::*;
#(
  parameter int OVC_W = `OVC_DEFAULT_W
)(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    op_valid,
  input  wire logic [15:0]             opcode,
  input  wire logic [15:0]             opcode_ext,
  input  wire logic [31:0]             operand,
  input  wire logic [31:0]             product,
  input  wire logic [2:0]              product_shift_field,
  input  wire logic                    saturation_mode_bit,
  input  wire logic                    code_compat_mode,
  input  wire logic                    repeat_prefix,
  input  wire logic [`REP_COUNT_W-1:0] repeat_count,
  output logic [31:0]                  sum_register,
  output logic                         zero_flag,
  output logic                         negative_flag,
  output logic                         carry_flag,
  output logic                         overflow_flag,
  output logic [OVC_W-1:0]             overflow_counter,
  output logic                         mem_write_valid,
  output logic [31:0]                  mem_write_data,
  output logic                         busy,
  output logic                         op_done,
  output logic [`REP_COUNT_W-1:0]      repeat_left
);

  adder_if add_bus ();

  seq_state_t state;
  op_kind_t   kind;

  wire        is_add_carry;
  wire        is_long_add;
  wire        is_add_prod;
  wire        is_add_to_mem;
  wire        is_legal;
  wire        accept;
  wire        exec;
  wire        repeatable;
  wire        start_repeat;
  wire        last_iter;
  wire        single_issue;
  op_kind_t   dec_kind;
  op_kind_t   cur_kind;
  wire [31:0] shifted_product;
  wire [31:0] next_sum;
  wire [OVC_W-1:0] next_ovc;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  assign is_add_carry  = (opcode[15:8] == `OP_ADD_CARRY_HI);
  assign is_long_add   = (opcode[15:8] == `OP_LONG_ADD_HI);
  assign is_add_prod   = (opcode == `OP_ADD_PRODUCT);
  assign is_add_to_mem = (opcode == `OP_ADD_TO_MEM) && code_compat_mode
                         && (opcode_ext[15:8] == `OP_ADD_TO_MEM_EXT);
  assign is_legal      = is_add_carry | is_long_add | is_add_prod | is_add_to_mem;
  assign dec_kind      = is_add_carry ? op_add_carry :
                         is_long_add ? op_long_add :
                         is_add_prod ? op_add_prod : op_add_to_mem;

  // -------------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------------
  assign accept       = (state == st_idle) && op_valid && is_legal;
  assign exec         = accept || (state == st_repeat);
  assign cur_kind     = (state == st_repeat) ? kind : dec_kind;
  assign repeatable   = (dec_kind == op_long_add) || (dec_kind == op_add_prod);
  assign start_repeat = accept && repeatable && repeat_prefix
                        && (repeat_count != '0);
  assign last_iter    = (repeat_left == `REP_COUNT_W'(1));
  assign single_issue = accept && !start_repeat;

  // -------------------------------------------------------------------
  // operand selection
  // -------------------------------------------------------------------
  assign shifted_product = (product_shift_field == `SHIFT_LEFT_ONE) ?
                           {product[30:0], 1'b0} :
                           32'($signed(product) >>>
                               (product_shift_field - `SHIFT_RIGHT_BIAS));

  assign add_bus.a   = (cur_kind == op_add_to_mem) ? operand : sum_register;
  assign add_bus.b   = (cur_kind == op_add_carry)  ? {16'h0000, operand[15:0]} :
                       (cur_kind == op_add_prod)   ? shifted_product :
                       (cur_kind == op_add_to_mem) ? sum_register : operand;
  assign add_bus.cin = (cur_kind == op_add_carry) ? carry_flag : 1'b0;
  assign add_bus.sat = saturation_mode_bit;

  sat_adder u_adder (
    .bus (add_bus)
  );

  assign next_sum = (cur_kind == op_add_to_mem) ? sum_register : add_bus.result;
  assign next_ovc = saturation_mode_bit ? overflow_counter :
                    add_bus.ovf_pos ? overflow_counter + OVC_W'(1) :
                    add_bus.ovf_neg ? overflow_counter - OVC_W'(1) :
                    overflow_counter;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state       <= st_idle;
      kind        <= op_add_carry;
      repeat_left <= '0;
      busy        <= 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          if (start_repeat) begin
            state       <= st_repeat;
            kind        <= dec_kind;
            repeat_left <= repeat_count;
            busy        <= 1'b1;
          end else if (accept) begin
            repeat_left <= '0;
          end
        end
        st_repeat: begin
          repeat_left <= repeat_left - `REP_COUNT_W'(1);
          if (last_iter) begin
            state <= st_idle;
            busy  <= 1'b0;
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // results and flags
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sum_register     <= `SUM_RESET;
      zero_flag        <= 1'b0;
      negative_flag    <= 1'b0;
      carry_flag       <= 1'b0;
      overflow_flag    <= 1'b0;
      overflow_counter <= '0;
      mem_write_valid  <= 1'b0;
      mem_write_data   <= 32'h00000000;
      op_done          <= 1'b0;
    end else begin
      mem_write_valid <= exec && (cur_kind == op_add_to_mem);
      op_done         <= (accept && !start_repeat)
                         || ((state == st_repeat) && last_iter);
      if (exec) begin
        sum_register     <= next_sum;
        zero_flag        <= (add_bus.result == 32'h00000000);
        negative_flag    <= add_bus.result[31];
        carry_flag       <= add_bus.carry;
        overflow_flag    <= overflow_flag | add_bus.ovf_pos | add_bus.ovf_neg;
        overflow_counter <= next_ovc;
        mem_write_data   <= add_bus.result;
      end
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  add_carry_decode_a: assert property (@(posedge clk) disable iff (rst)
    accept && opcode[15:8] == 8'h0c |-> cur_kind == op_add_carry && add_bus.cin == carry_flag)
    else $error("add with carry misdecoded");

  zero_flag_a: assert property (@(posedge clk) disable iff (rst)
    exec |=> zero_flag == ($past(add_bus.result) == 32'h00000000))
    else $error("zero flag wrong");

  neg_flag_a: assert property (@(posedge clk) disable iff (rst)
    exec |=> negative_flag == $past(add_bus.result[31]))
    else $error("negative flag wrong");

  carry_flag_a: assert property (@(posedge clk) disable iff (rst)
    exec && (add_bus.a[31] & add_bus.b[31]) |=> carry_flag)
    else $error("carry flag missed");

  sticky_ovf_a: assert property (@(posedge clk) disable iff (rst)
    overflow_flag |=> overflow_flag)
    else $error("overflow flag cleared");

  ovc_count_a: assert property (@(posedge clk) disable iff (rst)
    exec && !saturation_mode_bit && add_bus.ovf_pos
    |=> overflow_counter == $past(overflow_counter) + OVC_W'(1))
    else $error("overflow counter not incremented");

  ovc_hold_a: assert property (@(posedge clk) disable iff (rst)
    exec && saturation_mode_bit |=> $stable(overflow_counter))
    else $error("overflow counter moved while saturating");

  sat_pos_a: assert property (@(posedge clk) disable iff (rst)
    exec && saturation_mode_bit && add_bus.ovf_pos && cur_kind != op_add_to_mem
    |=> sum_register == 32'h7fffffff)
    else $error("positive saturation missing");

  repeat_len_a: assert property (@(posedge clk) disable iff (rst)
    start_repeat && repeat_count == 8'h03 |=> busy [*3] ##1 !busy)
    else $error("repeat length wrong");

  no_repeat_a: assert property (@(posedge clk) disable iff (rst)
    accept && !repeatable |=> !busy && repeat_left == '0 && op_done)
    else $error("unrepeatable form repeated");

  one_cycle_a: assert property (@(posedge clk) disable iff (rst)
    single_issue |=> op_done ##1 (op_done == $past(single_issue)))
    else $error("single add not done in one cycle");

endmodule

`default_nettype wire

// *** accumulator_add_family_tb.sv ***
// self-checking bench for the accumulator add datapath
// assumes the constants header, package, interface and design compile first
`timescale 1ns/10ps
`default_nettype none
`include "add_family_consts.svh"

module accumulator_add_family_tb;
  typedef struct {
    logic [31:0] sum;
    logic [31:0] mdat;
    logic        mem;
    logic [3:0]  f;
    logic [5:0]  ovc;
  } note_t;

  logic                    clk, rst, op_valid, saturation_mode_bit;
  logic                    code_compat_mode, repeat_prefix;
  logic [15:0]             opcode, opcode_ext;
  logic [31:0]             operand, product, sum_register, mem_write_data;
  logic [2:0]              product_shift_field;
  logic [`REP_COUNT_W-1:0] repeat_count, repeat_left;
  logic                    zero_flag, negative_flag, carry_flag, overflow_flag;
  logic                    mem_write_valid, busy, op_done;
  logic [5:0]              overflow_counter;
  int                      failures, samples_checked, i;
  logic [31:0]             model_sum;
  logic                    c, v;
  logic [5:0]              ovc;
  note_t                   notes[$];
  note_t                   seen;

  accumulator_add_family #(.OVC_W(6)) dut (
    .clk, .rst, .op_valid, .opcode, .opcode_ext, .operand, .product,
    .product_shift_field, .saturation_mode_bit, .code_compat_mode,
    .repeat_prefix, .repeat_count, .sum_register, .zero_flag, .negative_flag,
    .carry_flag, .overflow_flag, .overflow_counter, .mem_write_valid,
    .mem_write_data, .busy, .op_done, .repeat_left
  );

  always #12.5 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // returns {carry, positive overflow, negative overflow, result}
  function automatic logic [34:0] ref_add(input logic [31:0] a, b, input logic cin, s);
    logic [32:0] raw;
    logic        pos, neg;
    raw = {1'b0, a} + {1'b0, b} + 33'(cin);
    pos = !a[31] && !b[31] && raw[31];
    neg = a[31] && b[31] && !raw[31];
    if (s && pos) raw[31:0] = `SAT_POS_VALUE;
    if (s && neg) raw[31:0] = `SAT_NEG_VALUE;
    return {raw[32], pos, neg, raw[31:0]};
  endfunction

  // caller sits at a rising edge; kind 0 carry, 1 long, 2 product, 3 into memory
  task automatic run_op(input logic [1:0] kind, input logic [7:0] n, input logic s,
                        input logic [31:0] opd);
    logic [34:0] r;
    logic [31:0] b, pr;
    logic [2:0]  pf;
    logic [7:0]  lo;
    int          iters, k;
    pr = $urandom;
    pf = 3'($urandom);
    lo = 8'($urandom);
    iters = (kind == 2'd1 || kind == 2'd2) ? n + 1 : 1;
    for (k = 0; k < iters; k++) begin
      b = (kind == 2'd0) ? {16'h0000, opd[15:0]} : opd;
      // kept apart from the left shift so the right shift stays arithmetic
      if (kind == 2'd2 && pf == 3'h0) b = pr << 1;
      if (kind == 2'd2 && pf != 3'h0) b = 32'($signed(pr) >>> (pf - 3'h1));
      r = (kind == 2'd3) ? ref_add(opd, model_sum, 1'b0, s)
                         : ref_add(model_sum, b, !kind && c, s);
      c = r[34];
      v = v | r[33] | r[32];
      if (!s) ovc = ovc + 6'(r[33]) - 6'(r[32]);
      if (kind != 2'd3) model_sum = r[31:0];
    end
    notes.push_back('{model_sum, r[31:0], kind == 2'd3, {r[31:0] == 0, r[31], c, v}, ovc});
    op_valid <= 1'b1;
    opcode <= kind[1] ? (kind[0] ? `OP_ADD_TO_MEM : `OP_ADD_PRODUCT)
                      : {kind[0] ? `OP_LONG_ADD_HI : `OP_ADD_CARRY_HI, lo};
    opcode_ext <= {`OP_ADD_TO_MEM_EXT, lo};
    operand <= opd;
    product <= pr;
    product_shift_field <= pf;
    saturation_mode_bit <= s;
    repeat_prefix <= (n != 0);
    repeat_count <= n;
    @(posedge clk);
    // with iterations left, issue again in the first busy cycle: it must be ignored
    op_valid <= (iters > 1);
    k = 0;
    while (op_done !== 1'b1 && k < 300) begin
      @(posedge clk);
      if (k == 0 && iters > 1) op_valid <= 1'b0;
      chk("busy", 32'(busy), 32'(k < iters - 1));
      k++;
    end
    chk("latency", k, iters);
    if (k >= 300) summarize();
  endtask

  always @(negedge clk) begin
    if (op_done === 1'b1) begin
      if (notes.size() == 0) begin
        chk("unexpected op_done", 1, 0);
      end else begin
        seen = notes.pop_front();
        chk("sum_register", sum_register, seen.sum);
        chk("zero_negative", 32'({zero_flag, negative_flag}), 32'(seen.f[3:2]));
        chk("carry_overflow", 32'({carry_flag, overflow_flag}), 32'(seen.f[1:0]));
        chk("overflow_counter", 32'(overflow_counter), 32'(seen.ovc));
        chk("repeat_left", 32'(repeat_left), 0);
        chk("mem_write_valid", 32'(mem_write_valid), 32'(seen.mem));
        if (seen.mem) chk("mem_write_data", mem_write_data, seen.mdat);
      end
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {op_valid, saturation_mode_bit, repeat_prefix} = '0;
    code_compat_mode = 1'b1;
    {opcode, opcode_ext, operand, product} = '0;
    product_shift_field = 3'h0;
    repeat_count = '0;
    {model_sum, c, v, ovc, failures, samples_checked} = '0;
    void'($urandom(56682));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset sum", sum_register, `SUM_RESET);
    chk("reset flags", 32'({zero_flag, negative_flag, carry_flag, overflow_flag}), 0);
    chk("reset status", 32'({busy, op_done, mem_write_valid, overflow_counter}), 0);
    $display("test reset done");
    run_op(2'd1, 8'h00, 1'b0, 32'h00000000);
    run_op(2'd1, 8'h02, 1'b0, 32'h7fffffff);
    run_op(2'd1, 8'h01, 1'b1, 32'h80000000);
    for (i = 0; i < 80; i++) begin
      run_op(2'($urandom), 8'($urandom % 4), 1'($urandom), $urandom);
    end
    $display("test random ops done");
    @(posedge clk);
    code_compat_mode <= 1'b0;
    opcode <= `OP_ADD_TO_MEM;
    opcode_ext <= {`OP_ADD_TO_MEM_EXT, 8'h05};
    op_valid <= 1'b1;
    @(posedge clk);
    opcode <= 16'hff00;
    @(posedge clk);
    op_valid <= 1'b0;
    chk("refused memory write", 32'(mem_write_valid), 0);
    @(posedge clk);
    chk("refused illegal write", 32'(mem_write_valid), 0);
    repeat (2) @(posedge clk);
    chk("refused sum", sum_register, model_sum);
    code_compat_mode <= 1'b1;
    @(posedge clk);
    run_op(2'd3, 8'h00, 1'b0, $urandom);
    $display("test refusal done");
    summarize();
  end
endmodule

`default_nettype wire
